//--- src/sax_consts.vh
// Constants for the segment address extension block
`ifndef SAX_CONSTS_VH
`define SAX_CONSTS_VH
`define SAX_OFF_CODE_SEG    8'hf4
`define SAX_OFF_EXT_MODE2   8'hf6
`define SAX_OFF_INT_SEG     8'hf8
`define SAX_OFF_DMA_SEG     8'hf9
`define SAX_OFF_PORT0       8'he0
`define SAX_OFF_PAGE0       8'hf0
`define SAX_BIT_RELOCATE    5
`define SAX_BIT_SAVE_CS     6
`define SAX_SEG_W           6
`define SAX_CS_RESET        6'h00
`define SAX_EXTENDED_MODE_REG2_RESET      8'h00
`define SAX_VEC_RESET       16'h0000
`define SAX_VEC_DIVZERO     16'h0002
`define SAX_VEC_TOPLEVEL    16'h0004
`define SAX_FRAME_PCL       3'h0
`define SAX_FRAME_PCH       3'h1
`define SAX_FRAME_CS        3'h2
`define SAX_FRAME_FLAGS     3'h3
`define SAX_FRAME_NONE      3'h4
`endif

//--- src/sax_segment_ext.v
// Segment address extension: segment registers and physical address select
// Notes on behaviour
// RQ1: Interrupt service uses interrupt segment bits.
// RQ2: DMA with select clear uses interrupt segment.
// RQ3: DMA with select set uses DMA segment.
// RQ4: Software keeps top two bits at reset.
// RQ5: Software never writes code segment normally.
// RQ6: Code segment writable only when unused.
// RQ7: Far jump, call, return load code segment.
// RQ8: Relocate bit swaps page and port registers.
// RQ9: Mode clear: interrupt segment replaces code segment.
// RQ10: Mode set: push code segment, then load.
// RQ11: Mode set: interrupt return restores code segment.
// RQ12: Data mapping independent of save mode.
// RQ13: Vector table in first 256 bytes.
// RQ14: Reset vector at physical bytes zero, one.
// RQ15: Top-level vector at offsets four, five.
// RQ16: Shared vector: base high, hardware low bits.
// RQ17: Divide trap vectors at two, three.
// RQ18: Divide trap pushes no flags.
// RQ19: Eight external channels plus one top level.
// RQ20: Address is segment concatenated with virtual.
// RQ21: Code segment resets to zero.
// RQ22: Code segment pushed between PC and flags.
// RQ23: Interrupt and DMA segments reset undefined.
`include "sax_consts.vh"
module sax_segment_ext
#(
  parameter VEC_LOW_W  = 3,
  parameter NUM_EXT_CH = 8
)
(
  // Clock and reset
  input  wire                  clk_sys_i,
  input  wire                  rst_i,
  // Register file port
  input  wire                  reg_wr_i,
  input  wire [7:0]            reg_addr_i,
  input  wire [7:0]            reg_wdata_i,
  input  wire                  reg_page21_i,
  output reg  [7:0]            reg_rdata_o,
  // Register relocation
  input  wire [7:0]            map_addr_i,
  output wire                  map_is_page_reg_o,
  output wire [7:0]            map_addr_o,
  // Core sequencer
  input  wire                  fetch_i,
  input  wire                  int_active_i,
  input  wire                  int_entry_i,
  input  wire                  int_return_i,
  input  wire                  far_load_i,
  input  wire [5:0]            far_seg_i,
  input  wire                  pop_cs_i,
  input  wire [5:0]            pop_data_i,
  input  wire [15:0]           virt_addr_i,
  // DMA controller
  input  wire                  dma_active_i,
  input  wire                  dma_segment_select_i,
  // Vector generation
  input  wire                  vec_reset_i,
  input  wire                  vec_divzero_i,
  input  wire                  vec_toplevel_i,
  input  wire                  vec_channel_i,
  input  wire [7:0]            vector_base_reg_i,
  input  wire [VEC_LOW_W-1:0]  vec_low_i,
  input  wire [NUM_EXT_CH-1:0] ext_int_i,
  input  wire                  top_level_i,
  output wire                  int_request_o,
  output wire                  divzero_push_flags_o,
  // Stack frame and address outputs
  output reg  [2:0]            frame_next_o,
  output wire [5:0]            push_cs_o,
  output reg  [21:0]           phys_addr_o,
  output wire                  save_code_segment_mode_o,
  output wire                  page_reg_relocate_o
);

  reg  [5:0] code_segment_reg;
  reg  [5:0] code_segment_next;
  reg  [7:0] interrupt_segment_reg;
  reg  [7:0] dma_segment_reg;
  reg  [7:0] extended_mode_reg2_reg;
  reg  [NUM_EXT_CH-1:0] irq_sync1_reg;
  reg  [NUM_EXT_CH-1:0] irq_sync2_reg;
  reg        tl_sync1_reg;
  reg        tl_sync2_reg;
  reg  [5:0] seg_sel;
  reg  [15:0] off_sel;
  wire       save_cs;
  wire       relocate;
  reg  [7:0] rdata_next;
  wire       wr_code_seg;
  wire       wr_ext_mode2;
  wire       wr_int_seg;
  wire       wr_dma_seg;
  wire       cs_write_ok;
  wire       in_port_quad;
  wire       in_page_quad;

  function [21:0] sax_join;
    input [5:0]  seg;
    input [15:0] off;
    begin
      sax_join = {seg, off}; // RQ20
    end
  endfunction

  // Register write strobe decode
  function sax_hit;
    input       wr;
    input       page;
    input [7:0] addr;
    input [7:0] off;
    begin
      sax_hit = wr && page && (addr == off);
    end
  endfunction

  // Four-register window decode
  function sax_quad;
    input [7:0] addr;
    input [7:0] base;
    begin
      sax_quad = (addr[7:2] == base[7:2]);
    end
  endfunction

  // Move a register number into another four-register window
  function [7:0] sax_swap;
    input [7:0] addr;
    input [7:0] base;
    begin
      sax_swap = {base[7:2], addr[1:0]};
    end
  endfunction

  // Two-byte vector slot: fixed even offset plus byte select
  function [15:0] sax_vec_off;
    input [15:0] slot;
    input        byte_sel;
    begin
      sax_vec_off = {slot[15:1], byte_sel};
    end
  endfunction

  assign save_cs  = extended_mode_reg2_reg[`SAX_BIT_SAVE_CS];
  assign relocate = extended_mode_reg2_reg[`SAX_BIT_RELOCATE];
  assign save_code_segment_mode_o = save_cs;
  assign page_reg_relocate_o      = relocate;
  assign push_cs_o = code_segment_reg;
  assign divzero_push_flags_o = 1'b0; // RQ18

  // Register write decode
  assign wr_code_seg  = sax_hit(reg_wr_i, reg_page21_i, reg_addr_i, `SAX_OFF_CODE_SEG);
  assign wr_ext_mode2 = sax_hit(reg_wr_i, reg_page21_i, reg_addr_i, `SAX_OFF_EXT_MODE2);
  assign wr_int_seg   = sax_hit(reg_wr_i, reg_page21_i, reg_addr_i, `SAX_OFF_INT_SEG);
  assign wr_dma_seg   = sax_hit(reg_wr_i, reg_page21_i, reg_addr_i, `SAX_OFF_DMA_SEG);
  assign cs_write_ok  = int_active_i && !save_cs; // RQ6
  assign in_port_quad = sax_quad(map_addr_i, `SAX_OFF_PORT0);
  assign in_page_quad = sax_quad(map_addr_i, `SAX_OFF_PAGE0);

  // Page register swap with port data registers
  assign map_is_page_reg_o = relocate ? in_port_quad : in_page_quad; // RQ8
  assign map_addr_o = !relocate   ? map_addr_i :
                      in_port_quad ? sax_swap(map_addr_i, `SAX_OFF_PAGE0) :
                      in_page_quad ? sax_swap(map_addr_i, `SAX_OFF_PORT0) :
                      map_addr_i; // RQ8

  // External channel synchroniser
  always @(posedge clk_sys_i)
  begin
    irq_sync1_reg <= ext_int_i;
    irq_sync2_reg <= irq_sync1_reg;
  end

  // Top-level channel synchroniser
  always @(posedge clk_sys_i)
  begin
    tl_sync1_reg <= top_level_i;
    tl_sync2_reg <= tl_sync1_reg;
  end
  assign int_request_o = (|irq_sync2_reg) | tl_sync2_reg; // RQ19

  // Code segment next value
  always @*
  begin
    code_segment_next = code_segment_reg;
    if (wr_code_seg && cs_write_ok)
      code_segment_next = reg_wdata_i[5:0]; // RQ6
    if (far_load_i)
      code_segment_next = far_seg_i; // RQ7
    if (int_entry_i && save_cs)
      code_segment_next = interrupt_segment_reg[5:0]; // RQ10
    if (int_return_i && save_cs && pop_cs_i)
      code_segment_next = pop_data_i; // RQ11
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      code_segment_reg <= `SAX_CS_RESET; // RQ21
    else
      code_segment_reg <= code_segment_next;
  end

  // Mode bits for code segment save and page relocation
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      extended_mode_reg2_reg <= `SAX_EXTENDED_MODE_REG2_RESET;
    else if (wr_ext_mode2)
      extended_mode_reg2_reg <= reg_wdata_i;
  end

  // Segment registers with no reset value
  always @(posedge clk_sys_i)
  begin
    if (wr_int_seg)
      interrupt_segment_reg <= reg_wdata_i; // RQ23
    if (wr_dma_seg)
      dma_segment_reg <= reg_wdata_i; // RQ23
  end

  // Register readback select
  always @*
  begin
    rdata_next = 8'h00;
    if (reg_page21_i)
    begin
      case (reg_addr_i)
        `SAX_OFF_CODE_SEG:  rdata_next = {2'b00, code_segment_reg};
        `SAX_OFF_EXT_MODE2: rdata_next = extended_mode_reg2_reg;
        `SAX_OFF_INT_SEG:   rdata_next = interrupt_segment_reg;
        `SAX_OFF_DMA_SEG:   rdata_next = dma_segment_reg;
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  // Readback register, one cycle after the address
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= rdata_next;
  end

  // Interrupt stack frame order
  always @*
  begin
    frame_next_o = `SAX_FRAME_NONE;
    if (int_entry_i)
    begin
      if (save_cs)
        frame_next_o = `SAX_FRAME_CS; // RQ22
      else
        frame_next_o = `SAX_FRAME_FLAGS; // RQ22
    end
  end

  // Segment and offset selection
  always @*
  begin
    seg_sel = code_segment_reg;
    off_sel = virt_addr_i;
    if (dma_active_i)
    begin
      if (dma_segment_select_i)
        seg_sel = dma_segment_reg[5:0]; // RQ3
      else
        seg_sel = interrupt_segment_reg[5:0]; // RQ2
    end
    else if (vec_reset_i)
    begin
      seg_sel = `SAX_CS_RESET;
      off_sel = sax_vec_off(`SAX_VEC_RESET, virt_addr_i[0]); // RQ14
    end
    else if (vec_divzero_i)
      off_sel = sax_vec_off(`SAX_VEC_DIVZERO, virt_addr_i[0]); // RQ17
    else if (vec_toplevel_i)
    begin
      seg_sel = interrupt_segment_reg[5:0];
      off_sel = sax_vec_off(`SAX_VEC_TOPLEVEL, virt_addr_i[0]); // RQ15
    end
    else if (vec_channel_i)
    begin
      seg_sel = interrupt_segment_reg[5:0]; // RQ13
      off_sel = {8'h00, vector_base_reg_i[7:VEC_LOW_W], vec_low_i}; // RQ16
    end
    else if (fetch_i && int_active_i && !save_cs)
      seg_sel = interrupt_segment_reg[5:0]; // RQ1 RQ9
  end

  // Data accesses keep normal paging, unaffected by save mode
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      phys_addr_o <= 22'h000000;
    else
      phys_addr_o <= sax_join(seg_sel, off_sel); // RQ12 RQ20
  end

endmodule // sax_segment_ext

//--- sim/sax_segment_ext_asserts.sv
// Concurrent checks on the segment address extension ports
module sax_segment_ext_asserts (
  input logic        clk_sys_i, rst_i, reg_wr_i, reg_page21_i, fetch_i, int_active_i,
  input logic        int_entry_i, int_return_i, far_load_i, pop_cs_i, dma_active_i,
  input logic        dma_segment_select_i, vec_reset_i, vec_divzero_i, vec_toplevel_i,
  input logic        vec_channel_i, save_code_segment_mode_o, divzero_push_flags_o,
  input logic [7:0]  reg_addr_i, reg_wdata_i,
  input logic [5:0]  far_seg_i, pop_data_i, push_cs_o,
  input logic [2:0]  frame_next_o,
  input logic [15:0] virt_addr_i,
  input logic [21:0] phys_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] int_seg, dma_seg;
  wire sm  = save_code_segment_mode_o;
  wire v0  = virt_addr_i[0];
  wire dm  = dma_active_i;
  wire vec = vec_reset_i | vec_divzero_i | vec_toplevel_i | vec_channel_i;
  wire wr  = reg_wr_i & reg_page21_i;
  always_ff @(posedge clk_sys_i)
    if (wr && reg_addr_i == 8'hf8) int_seg <= reg_wdata_i[5:0];
  always_ff @(posedge clk_sys_i)
    if (wr && reg_addr_i == 8'hf9) dma_seg <= reg_wdata_i[5:0];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_entry;
    int_entry_i && sm && !pop_cs_i;
  endsequence
  AST_DMA_SEG: assert property (dm && dma_segment_select_i |=>
    phys_addr_o == {$past(dma_seg), $past(virt_addr_i)}) else $error("dma segment address");
  AST_DMA_INT: assert property (dm && !dma_segment_select_i |=>
    phys_addr_o == {$past(int_seg), $past(virt_addr_i)}) else $error("dma int address");
  AST_ISR_FETCH: assert property (fetch_i && int_active_i && !sm && !dm && !vec |=>
    phys_addr_o == {$past(int_seg), $past(virt_addr_i)}) else $error("isr fetch address");
  AST_CS_FETCH: assert property (fetch_i && !int_active_i && !dm && !vec |=>
    phys_addr_o == {$past(push_cs_o), $past(virt_addr_i)}) else $error("code fetch address");
  AST_RST_VEC: assert property (vec_reset_i && !dm |=>
    phys_addr_o == {21'h0, $past(v0)}) else $error("reset vector address");
  AST_TOP_VEC: assert property (vec_toplevel_i && !dm && !vec_reset_i && !vec_divzero_i |=>
    phys_addr_o == {$past(int_seg), 15'h0002, $past(v0)}) else $error("top vector address");
  AST_DIV_VEC: assert property (vec_divzero_i && !dm && !vec_reset_i |=>
    phys_addr_o == {$past(push_cs_o), 15'h0001, $past(v0)}) else $error("divide vector");
  AST_NO_FLAGS: assert property (vec_divzero_i |-> !divzero_push_flags_o)
    else $error("divide trap pushes flags");
  AST_CS_LOAD: assert property (s_entry |=> push_cs_o == $past(int_seg))
    else $error("entry load");
  AST_FRAME_ORDER: assert property (int_entry_i |->
    frame_next_o == (sm ? 3'h2 : 3'h3)) else $error("entry frame order");
  AST_FAR: assert property (far_load_i && !int_entry_i && !pop_cs_i |=>
    push_cs_o == $past(far_seg_i)) else $error("far load");
  AST_POP: assert property (pop_cs_i && int_return_i && sm |=>
    push_cs_o == $past(pop_data_i)) else $error("return restore");
  AST_CS_REFUSE: assert property (wr && reg_addr_i == 8'hf4 && !int_active_i && !far_load_i
    && !int_entry_i && !pop_cs_i |=> $stable(push_cs_o)) else $error("code segment written");
endmodule // sax_segment_ext_asserts

//--- sim/sax_core_model.sv
// Core sequencer and DMA controller stand-in driving access levels
module sax_core_model (
  input  logic [2:0] op_i,
  output logic       fetch_o, int_active_o, dma_active_o, dma_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign fetch_o      = op_i == 3'h1 || op_i == 3'h2;
  assign int_active_o = op_i == 3'h2;
  assign dma_active_o = op_i[2];
  assign dma_sel_o    = op_i == 3'h5;
endmodule // sax_core_model

//--- sim/sax_segment_ext_tb.sv
// Self-checking bench for the segment address extension block
module sax_segment_ext_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_i, reg_wr_i, reg_page21_i, fetch_i, int_active_i, int_entry_i;
  logic int_return_i, far_load_i, pop_cs_i, dma_active_i, dma_segment_select_i, top_level_i;
  logic vec_reset_i, vec_divzero_i, vec_toplevel_i, vec_channel_i, int_request_o;
  logic divzero_push_flags_o, map_is_page_reg_o, save_code_segment_mode_o, page_reg_relocate_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, map_addr_i, map_addr_o;
  logic [7:0]  vector_base_reg_i, ext_int_i;
  logic [5:0]  far_seg_i, pop_data_i, push_cs_o;
  logic [15:0] virt_addr_i;
  logic [21:0] phys_addr_o;
  logic [2:0]  vec_low_i, frame_next_o, op;
  int          fail_count, tests_run, cyc;
  sax_segment_ext i_sax_segment_ext (.*);
  sax_core_model i_sax_core_model (.op_i(op), .fetch_o(fetch_i), .int_active_o(int_active_i),
    .dma_active_o(dma_active_i), .dma_sel_o(dma_segment_select_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      end_sim;
    end
  end
  task automatic chk(input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    reg_addr_i = a;
    @(negedge clk_sys_i);
    chk(reg_rdata_o, exp);
  endtask
  task automatic ax(input logic [2:0] o, input logic [15:0] v, input logic [21:0] exp);
    op = o;
    virt_addr_i = v;
    @(negedge clk_sys_i);
    chk(phys_addr_o, exp);
    {op, vec_reset_i, vec_toplevel_i, vec_divzero_i, vec_channel_i} = '0;
  endtask
  initial
  begin
    {reg_wr_i, int_entry_i, int_return_i, far_load_i, pop_cs_i, top_level_i, op} = '0;
    {vec_reset_i, vec_divzero_i, vec_toplevel_i, vec_channel_i, far_seg_i, pop_data_i} = '0;
    {reg_addr_i, reg_wdata_i, map_addr_i, vector_base_reg_i, ext_int_i, vec_low_i} = '0;
    {virt_addr_i, fail_count, tests_run, cyc} = '0;
    reg_page21_i = 1'b1;
    rst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rd(8'hf4, 8'h00);
    chk(int_request_o, 1'b0);
    wr(8'hf8, 8'h05);
    wr(8'hf9, 8'h2a);
    rd(8'hf8, 8'h05);
    rd(8'hf9, 8'h2a);
    rd(8'he5, 8'h00);
    ax(3'h5, 16'h1234, {6'h2a, 16'h1234});
    ax(3'h4, 16'hbeef, {6'h05, 16'hbeef});
    ax(3'h2, 16'h0100, {6'h05, 16'h0100});
    op = 3'h2;
    wr(8'hf4, 8'h07);
    op = 3'h1;
    wr(8'hf4, 8'h09);
    ax(3'h1, 16'h4000, {6'h07, 16'h4000});
    vec_reset_i = 1'b1;
    ax(3'h0, 16'h0001, 22'h000001);
    vec_toplevel_i = 1'b1;
    ax(3'h0, 16'h0001, {6'h05, 16'h0005});
    vec_divzero_i = 1'b1;
    chk(divzero_push_flags_o, 1'b0);
    ax(3'h0, 16'h0000, {6'h07, 16'h0002});
    {vector_base_reg_i, vec_low_i, vec_channel_i} = {8'h40, 3'h5, 1'b1};
    ax(3'h0, 16'h0000, {6'h05, 16'h0045});
    int_entry_i = 1'b1;
    #1;
    chk(frame_next_o, 3'h3);
    @(negedge clk_sys_i);
    int_entry_i = 1'b0;
    chk(push_cs_o, 6'h07);
    wr(8'hf6, 8'h40);
    chk(save_code_segment_mode_o, 1'b1);
    int_entry_i = 1'b1;
    #1;
    chk(frame_next_o, 3'h2);
    @(negedge clk_sys_i);
    int_entry_i = 1'b0;
    chk(push_cs_o, 6'h05);
    ax(3'h2, 16'h0020, {6'h05, 16'h0020});
    ax(3'h4, 16'h0010, {6'h05, 16'h0010});
    {far_load_i, far_seg_i} = {1'b1, 6'h11};
    @(negedge clk_sys_i);
    far_load_i = 1'b0;
    chk(push_cs_o, 6'h11);
    {int_return_i, pop_cs_i, pop_data_i} = {2'b11, 6'h07};
    @(negedge clk_sys_i);
    {int_return_i, pop_cs_i} = 2'b00;
    chk(push_cs_o, 6'h07);
    wr(8'hf6, 8'h20);
    map_addr_i = 8'he1;
    #1;
    chk(map_addr_o, 8'hf1);
    chk(page_reg_relocate_o, 1'b1);
    chk(map_is_page_reg_o, 1'b1);
    ext_int_i = 8'h08;
    repeat (3) @(negedge clk_sys_i);
    chk(int_request_o, 1'b1);
    {ext_int_i, top_level_i} = {8'h00, 1'b1};
    repeat (3) @(negedge clk_sys_i);
    chk(int_request_o, 1'b1);
    end_sim;
  end
endmodule // sax_segment_ext_tb
bind sax_segment_ext sax_segment_ext_asserts i_sax_segment_ext_asserts (.*);
